// *** rtl/timer_two_pkg.sv ***
package timer_two_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL = 8'hc8;
	localparam logic [7:0] ADDR_MODE = 8'hc9;
	localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
	localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
	localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
	localparam logic [7:0] ADDR_BIT_SET = 8'hce;
	localparam logic [7:0] ADDR_BIT_CLEAR = 8'hcf;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_TOP = 16'hffff;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_OVF = 7;
	localparam int BIT_EXF = 6;
	localparam int BIT_RCLK = 5;
	localparam int BIT_TRANSMIT_CLOCK_SELECT = 4;
	localparam int BIT_TEN = 3;
	localparam int BIT_RUN = 2;
	localparam int BIT_CSEL = 1;
	localparam int BIT_CAP = 0;
	localparam int BIT_OE = 1;
	localparam int BIT_UP_DOWN_ENABLE = 0;
	localparam int SYNC_STAGES = 2;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef struct packed {
		logic out;
		logic oe_n;
	} pin_drive_s;
endpackage

// *** rtl/timer_two.sv ***
`timescale 1ns/10ps
module timer_two
	import timer_two_pkg::*;
#(
	parameter int COUNT_WIDTH = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	input wire logic clk_en,
	// Register port
	input wire timer_two_pkg::reg_req_s req,
	output logic [7:0] rdata,
	// Pins
	input wire logic count_clock_pin_in,
	output timer_two_pkg::pin_drive_s count_clock_pin_drv,
	input wire logic trigger_direction_pin,
	// Serial port and interrupt
	input wire logic other_timer_ovf,
	output logic serial_rx_tick,
	output logic serial_tx_tick,
	output logic timer_irq
);
	import timer_two_pkg::*;

	// Byte cascade and wrap compares assume sixteen bits
	if (COUNT_WIDTH != 16) begin
		$error("timer_two supports only a 16-bit count");
	end

	logic [7:0] ctrl_q;
	logic [1:0] mode_q;
	logic [15:0] reload_q;
	logic [15:0] count_q;
	logic [15:0] capture_q;
	logic clkout_q;
	logic half_q;
	logic [SYNC_STAGES-1:0] t2_sync_q;
	logic [SYNC_STAGES-1:0] ex_sync_q;
	logic t2_last_q;
	logic ex_last_q;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			t2_sync_q <= '0;
			ex_sync_q <= '0;
			t2_last_q <= 1'b0;
			ex_last_q <= 1'b0;
		end else if (clk_en) begin
			t2_sync_q <= {t2_sync_q[0], count_clock_pin_in};
			ex_sync_q <= {ex_sync_q[0], trigger_direction_pin};
			t2_last_q <= t2_sync_q[1];
			ex_last_q <= ex_sync_q[1];
		end
	end

	logic t2_fall;
	logic ex_fall;
	logic ex_level;
	assign t2_fall = t2_last_q & ~t2_sync_q[1];
	assign ex_fall = ex_last_q & ~ex_sync_q[1];
	assign ex_level = ex_sync_q[1];

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	logic run;
	logic baud;
	logic clkout_mode;
	logic updown;
	logic capture_mode;
	logic tick;
	logic trig;
	assign run = ctrl_q[BIT_RUN];
	assign baud = ctrl_q[BIT_RCLK] | ctrl_q[BIT_TRANSMIT_CLOCK_SELECT];
	assign clkout_mode = mode_q[BIT_OE];
	assign capture_mode = ctrl_q[BIT_CAP] & ~baud;
	assign updown = mode_q[BIT_UP_DOWN_ENABLE] & ~capture_mode;
	// Internal clock: clock-out and baud modes count at half rate, timer otherwise every cycle
	assign tick = run & (ctrl_q[BIT_CSEL] ? t2_fall :
		((clkout_mode | baud) ? half_q : 1'b1));
	assign trig = ctrl_q[BIT_TEN] & ex_fall & ~baud & ~updown;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			half_q <= 1'b0;
		else if (clk_en)
			half_q <= run ? ~half_q : 1'b0;
	end

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	logic count_up;
	logic wrap_up;
	logic wrap_down;
	logic wrap;
	assign count_up = ~updown | ex_level;
	assign wrap_up = tick & count_up & (count_q == COUNT_TOP);
	assign wrap_down = tick & ~count_up & (count_q == reload_q);
	assign wrap = wrap_up | wrap_down;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count_q <= COUNT_RESET;
		end else if (clk_en) begin
			if (req.wr && req.addr == ADDR_COUNT_LOW)
				count_q[7:0] <= req.wdata;
			else if (req.wr && req.addr == ADDR_COUNT_HIGH)
				count_q[15:8] <= req.wdata;
			else if (wrap_down)
				count_q <= COUNT_TOP;
			else if (wrap_up && !capture_mode)
				count_q <= reload_q;
			else if (trig && !capture_mode)
				count_q <= reload_q;
			else if (tick)
				count_q <= count_up ? count_q + 16'h0001 : count_q - 16'h0001;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			capture_q <= COUNT_RESET;
		else if (clk_en && trig && capture_mode)
			capture_q <= count_q;
	end

	// ------------------------------------------------------------
	// Clock output
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			clkout_q <= 1'b0;
		else if (clk_en && clkout_mode && wrap_up)
			clkout_q <= ~clkout_q;
	end

	assign count_clock_pin_drv = '{out: clkout_q, oe_n: ~clkout_mode};

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic ctl_wr;
	logic set_wr;
	logic clr_wr;
	logic ovf_set;
	logic exf_set;
	logic exf_tog;
	assign ctl_wr = req.wr && req.addr == ADDR_CONTROL;
	assign set_wr = req.wr && req.addr == ADDR_BIT_SET;
	assign clr_wr = req.wr && req.addr == ADDR_BIT_CLEAR;
	// Clock-out and baud modes both suppress the overflow flag
	assign ovf_set = wrap & ~baud & ~clkout_mode;
	assign exf_set = trig;
	assign exf_tog = updown & wrap;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= CONTROL_RESET;
		end else if (clk_en) begin
			if (ctl_wr)
				ctrl_q <= req.wdata;
			else if (set_wr)
				ctrl_q <= ctrl_q | req.wdata;
			else if (clr_wr)
				ctrl_q <= ctrl_q & ~req.wdata;
			// Hardware set wins over a software clear in the same cycle
			if (ovf_set)
				ctrl_q[BIT_OVF] <= 1'b1;
			if (exf_tog)
				ctrl_q[BIT_EXF] <= ~ctrl_q[BIT_EXF];
			else if (exf_set)
				ctrl_q[BIT_EXF] <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mode_q <= MODE_RESET[1:0];
			reload_q <= COUNT_RESET;
		end else if (clk_en && req.wr) begin
			if (req.addr == ADDR_MODE)
				mode_q <= req.wdata[1:0];
			if (req.addr == ADDR_RELOAD_LOW)
				reload_q[7:0] <= req.wdata;
			if (req.addr == ADDR_RELOAD_HIGH)
				reload_q[15:8] <= req.wdata;
		end
	end

	// Capture shares the reload address in capture mode, as one holding pair
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdata <= 8'h00;
		end else if (clk_en) begin
			rdata <= 8'h00;
			if (req.rd) begin
				unique case (req.addr)
					ADDR_CONTROL: rdata <= ctrl_q;
					ADDR_MODE: rdata <= {6'h00, mode_q};
					ADDR_RELOAD_LOW: rdata <= capture_mode ? capture_q[7:0] : reload_q[7:0];
					ADDR_RELOAD_HIGH: rdata <= capture_mode ? capture_q[15:8] : reload_q[15:8];
					ADDR_COUNT_LOW: rdata <= count_q[7:0];
					ADDR_COUNT_HIGH: rdata <= count_q[15:8];
					default: rdata <= 8'h00;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Serial clocks and interrupt
	// ------------------------------------------------------------
	assign serial_rx_tick = ctrl_q[BIT_RCLK] ? (clk_en & wrap_up) : other_timer_ovf;
	assign serial_tx_tick = ctrl_q[BIT_TRANSMIT_CLOCK_SELECT] ? (clk_en & wrap_up) : other_timer_ovf;
	assign timer_irq = ctrl_q[BIT_OVF] | (ctrl_q[BIT_EXF] & ~mode_q[BIT_UP_DOWN_ENABLE]);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_up_reload;
		@(posedge clock) disable iff (!rstn)
		(clk_en && wrap_up && !capture_mode && !req.wr) |=> (count_q == $past(reload_q));
	endproperty
	a_up_reload: assert property (p_up_reload) else $error("no reload on overflow");

	property p_down_top;
		@(posedge clock) disable iff (!rstn)
		(clk_en && wrap_down && !req.wr) |=> (count_q == COUNT_TOP);
	endproperty
	a_down_top: assert property (p_down_top) else $error("no ffff load on underflow");

	property p_stopped;
		@(posedge clock) disable iff (!rstn)
		(clk_en && !run && !req.wr && !trig) |=> $stable(count_q);
	endproperty
	a_stopped: assert property (p_stopped) else $error("count moved while stopped");

	property p_ovf_baud;
		@(posedge clock) disable iff (!rstn)
		(baud && !ctrl_q[BIT_OVF] && !req.wr) |=> !ctrl_q[BIT_OVF];
	endproperty
	a_ovf_baud: assert property (p_ovf_baud) else $error("overflow flag set in baud mode");

	property p_exf_toggle;
		@(posedge clock) disable iff (!rstn)
		(clk_en && exf_tog) |=> (ctrl_q[BIT_EXF] != $past(ctrl_q[BIT_EXF]));
	endproperty
	a_exf_toggle: assert property (p_exf_toggle) else $error("external flag not toggled");

	property p_capture;
		@(posedge clock) disable iff (!rstn)
		(clk_en && trig && capture_mode) |=> (capture_q == $past(count_q)) && ctrl_q[BIT_EXF];
	endproperty
	a_capture: assert property (p_capture) else $error("capture missed");

	property p_oe;
		@(posedge clock) disable iff (!rstn)
		count_clock_pin_drv.oe_n == !mode_q[BIT_OE];
	endproperty
	a_oe: assert property (p_oe) else $error("pin direction wrong");

	property p_no_trig_unenabled;
		@(posedge clock) disable iff (!rstn)
		(!ctrl_q[BIT_TEN] || baud) |-> !trig;
	endproperty
	a_no_trig_unenabled: assert property (p_no_trig_unenabled) else $error("trigger not gated");

	property p_up_step;
		@(posedge clock) disable iff (!rstn)
		(clk_en && tick && count_up && !wrap_up && !req.wr && !trig) |=>
			(count_q == $past(count_q) + 16'h0001);
	endproperty
	a_up_step: assert property (p_up_step) else $error("count did not step up");

	property p_down_step;
		@(posedge clock) disable iff (!rstn)
		(clk_en && tick && !count_up && !wrap_down && !req.wr) |=>
			(count_q == $past(count_q) - 16'h0001);
	endproperty
	a_down_step: assert property (p_down_step) else $error("count did not step down");

	property p_capture_wrap;
		@(posedge clock) disable iff (!rstn)
		(clk_en && wrap_up && capture_mode && !req.wr) |=> (count_q == COUNT_RESET);
	endproperty
	a_capture_wrap: assert property (p_capture_wrap) else $error("capture mode reloaded");

	property p_ovf_set;
		@(posedge clock) disable iff (!rstn)
		(clk_en && wrap && !baud && !clkout_mode) |=> ctrl_q[BIT_OVF];
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

	property p_clkout_no_ovf;
		@(posedge clock) disable iff (!rstn)
		(clkout_mode && !ctrl_q[BIT_OVF] && !req.wr) |=> !ctrl_q[BIT_OVF];
	endproperty
	a_clkout_no_ovf: assert property (p_clkout_no_ovf) else $error("clock-out set flag");

	property p_clkout_toggle;
		@(posedge clock) disable iff (!rstn)
		(clk_en && clkout_mode && wrap_up) |=>
			(count_clock_pin_drv.out != $past(count_clock_pin_drv.out));
	endproperty
	a_clkout_toggle: assert property (p_clkout_toggle) else $error("clock-out missed");

	property p_pin_hold;
		@(posedge clock) disable iff (!rstn)
		!(clk_en && clkout_mode && wrap_up) |=> $stable(count_clock_pin_drv.out);
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("clock-out moved early");

	property p_half_rate;
		@(posedge clock) disable iff (!rstn)
		(clk_en && tick && (clkout_mode || baud) && !ctrl_q[BIT_CSEL] && !req.wr) |=> !tick;
	endproperty
	a_half_rate: assert property (p_half_rate) else $error("count not at half rate");

	property p_freeze;
		@(posedge clock) disable iff (!rstn)
		!clk_en |=> ($stable(count_q) && $stable(ctrl_q) && $stable(mode_q) && $stable(reload_q));
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");

	property p_trig_reload;
		@(posedge clock) disable iff (!rstn)
		(clk_en && trig && !capture_mode && !wrap && !req.wr) |=>
			((count_q == $past(reload_q)) && ctrl_q[BIT_EXF]);
	endproperty
	a_trig_reload: assert property (p_trig_reload) else $error("trigger reload missed");

	property p_bit_set;
		@(posedge clock) disable iff (!rstn)
		(clk_en && set_wr && !exf_tog) |=> ((ctrl_q & $past(req.wdata)) == $past(req.wdata));
	endproperty
	a_bit_set: assert property (p_bit_set) else $error("bit set lost");

	property p_bit_clear;
		@(posedge clock) disable iff (!rstn)
		(clk_en && clr_wr && !ovf_set && !exf_set && !exf_tog) |=>
			((ctrl_q & $past(req.wdata)) == 8'h00);
	endproperty
	a_bit_clear: assert property (p_bit_clear) else $error("bit clear lost");

	property p_sync_single;
		@(posedge clock) disable iff (!rstn)
		(clk_en && t2_fall) |=> !t2_fall;
	endproperty
	a_sync_single: assert property (p_sync_single) else $error("one edge counted twice");

	property p_rx_other;
		@(posedge clock) disable iff (!rstn)
		!ctrl_q[BIT_RCLK] |-> (serial_rx_tick == other_timer_ovf);
	endproperty
	a_rx_other: assert property (p_rx_other) else $error("receive clock not routed");

	property p_tx_other;
		@(posedge clock) disable iff (!rstn)
		!ctrl_q[BIT_TRANSMIT_CLOCK_SELECT] |-> (serial_tx_tick == other_timer_ovf);
	endproperty
	a_tx_other: assert property (p_tx_other) else $error("transmit clock not routed");
endmodule

// *** dv/pin_far_side.sv ***
`timescale 1ns/10ps
module pin_far_side (
	// Clock
	input wire logic clock,
	// Pins toward the timer
	output logic cnt_pin,
	output logic trig_pin,
	output logic ovf_pulse
);
	// Count and trigger pins idle high; each level held 4 cycles so the pin sync cannot miss it
	initial begin
		cnt_pin = 1'b1;
		trig_pin = 1'b1;
		ovf_pulse = 1'b0;
	end
	task automatic fall_cnt(input int n);
		repeat (n) begin
			cnt_pin <= 1'b0;
			repeat (4) @(posedge clock);
			cnt_pin <= 1'b1;
			repeat (4) @(posedge clock);
		end
	endtask
	task automatic fall_trig();
		trig_pin <= 1'b0;
		repeat (4) @(posedge clock);
		trig_pin <= 1'b1;
		repeat (4) @(posedge clock);
	endtask
	task automatic set_dir(input logic v);
		trig_pin <= v;
		repeat (4) @(posedge clock);
	endtask
	task automatic tick_ovf();
		ovf_pulse <= 1'b1;
		@(posedge clock);
		ovf_pulse <= 1'b0;
	endtask
endmodule

// *** dv/tb_timer_two.sv ***
`timescale 1ns/10ps
module tb_timer_two;
	import timer_two_pkg::*;
	logic clock, rstn, clk_en, cnt_pin, trig_pin, ovf, rx, tx, irq;
	reg_req_s req;
	logic [7:0] rdata;
	pin_drive_s drv;
	int n_mismatch = 0;
	int tests_run = 0;
	timer_two DUT (.clock(clock), .rstn(rstn), .clk_en(clk_en), .req(req), .rdata(rdata),
		.count_clock_pin_in(cnt_pin), .count_clock_pin_drv(drv),
		.trigger_direction_pin(trig_pin), .other_timer_ovf(ovf), .serial_rx_tick(rx),
		.serial_tx_tick(tx), .timer_irq(irq));
	pin_far_side FAR (.clock(clock), .cnt_pin(cnt_pin), .trig_pin(trig_pin), .ovf_pulse(ovf));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// ------------------------------------------------------------
	// Bus and compare helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clock);
		req <= '0;
		@(posedge clock);
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, e);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock);
		req <= '0;
		#1 chk(rdata, e);
		@(posedge clock);
	endtask
	task automatic load(input logic [15:0] r, c);
		wr(ADDR_RELOAD_LOW, r[7:0]);
		wr(ADDR_RELOAD_HIGH, r[15:8]);
		wr(ADDR_COUNT_LOW, c[7:0]);
		wr(ADDR_COUNT_HIGH, c[15:8]);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_counter();
		wr(ADDR_CONTROL, 8'h06);
		FAR.fall_cnt(5);
		rd(ADDR_COUNT_LOW, 8'h05);
		wr(ADDR_BIT_CLEAR, 8'h04);
		FAR.fall_cnt(2);
		rd(ADDR_COUNT_LOW, 8'h05);
	endtask
	task automatic t_reload();
		load(16'h1234, 16'hfff0);
		wr(ADDR_CONTROL, 8'h04);
		repeat (40) @(posedge clock);
		wr(ADDR_BIT_CLEAR, 8'h04);
		rd(ADDR_COUNT_HIGH, 8'h12);
		rd(ADDR_CONTROL, 8'h80);
		chk(irq, 1'b1);
		wr(ADDR_BIT_CLEAR, 8'h80);
		rd(ADDR_CONTROL, 8'h00);
		chk(irq, 1'b0);
	endtask
	task automatic t_serial();
		logic seen;
		seen = 1'b0;
		load(16'hfff0, 16'hfff8);
		wr(ADDR_CONTROL, 8'h35);
		repeat (40) begin
			@(posedge clock);
			#1 seen |= rx & tx;
		end
		@(posedge clock);
		chk(seen, 1'b1);
		rd(ADDR_CONTROL, 8'h35);
		rd(ADDR_COUNT_HIGH, 8'hff);
		wr(ADDR_CONTROL, 8'h20);
		fork
			FAR.tick_ovf();
			#1 chk({rx, tx}, 8'h01);
		join
	endtask
	task automatic t_trigger();
		load(16'h1234, 16'h0055);
		wr(ADDR_CONTROL, 8'h06);
		FAR.fall_trig();
		rd(ADDR_COUNT_LOW, 8'h55);
		wr(ADDR_CONTROL, 8'h0e);
		FAR.fall_trig();
		rd(ADDR_COUNT_LOW, 8'h34);
		rd(ADDR_COUNT_HIGH, 8'h12);
		rd(ADDR_CONTROL, 8'h4e);
		chk(irq, 1'b1);
		wr(ADDR_BIT_CLEAR, 8'h40);
		wr(ADDR_COUNT_LOW, 8'hab);
		wr(ADDR_BIT_SET, 8'h01);
		FAR.fall_trig();
		rd(ADDR_RELOAD_LOW, 8'hab);
		rd(ADDR_CONTROL, 8'h4f);
	endtask
	task automatic t_updown();
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_MODE, 8'h01);
		FAR.set_dir(1'b0);
		load(16'hfff0, 16'hfff4);
		wr(ADDR_CONTROL, 8'h04);
		repeat (8) @(posedge clock);
		wr(ADDR_BIT_CLEAR, 8'h04);
		rd(ADDR_COUNT_HIGH, 8'hff);
		rd(ADDR_CONTROL, 8'hc0);
		wr(ADDR_BIT_CLEAR, 8'h80);
		rd(ADDR_CONTROL, 8'h40);
		chk(irq, 1'b0);
		FAR.set_dir(1'b1);
	endtask
	// Start order matters: run goes last so the first period is whole
	task automatic t_clkout();
		int last, per;
		logic prev;
		last = -1;
		per = 0;
		prev = 1'b0;
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_MODE, 8'h02);
		load(16'hfffe, 16'hfffe);
		wr(ADDR_BIT_SET, 8'h04);
		chk(drv.oe_n, 1'b0);
		for (int i = 0; i < 40; i++) begin
			@(posedge clock);
			#1;
			if (drv.out && !prev) begin
				if (last >= 0) per = i - last;
				last = i;
			end
			prev = drv.out;
		end
		@(posedge clock);
		chk(per[7:0], 8'h08);
		rd(ADDR_CONTROL, 8'h04);
	endtask
	// Clock enable low must hold the count; one tick lands on each side
	task automatic t_freeze();
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_MODE, 8'h00);
		load(16'h0000, 16'h0010);
		wr(ADDR_CONTROL, 8'h04);
		clk_en <= 1'b0;
		repeat (10) @(posedge clock);
		clk_en <= 1'b1;
		wr(ADDR_BIT_CLEAR, 8'h04);
		rd(ADDR_COUNT_LOW, 8'h12);
	endtask
	// ------------------------------------------------------------
	// Sequence, watchdog and verdict
	// ------------------------------------------------------------
	task automatic end_sim();
		$display("mismatches=%0d compares=%0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		rstn = 1'b0;
		clk_en = 1'b1;
		req = '0;
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		rd(ADDR_CONTROL, 8'h00);
		rd(ADDR_MODE, 8'h00);
		chk(drv.oe_n, 1'b1);
		rd(8'h10, 8'h00);
		t_counter();
		t_reload();
		t_serial();
		t_trigger();
		t_updown();
		t_clkout();
		t_freeze();
		end_sim();
	end
	// Whole sequence needs about 380 cycles
	initial begin
		repeat (5000) @(posedge clock);
		n_mismatch++;
		end_sim();
	end
endmodule
